//--- include/sas_pkg.sv
package sas_pkg;
  // slave addresses chosen by the straps
  localparam logic [6:0] ADDR_DEFAULT = 7'h2e;
  localparam logic [6:0] ADDR_SEL_LOW = 7'h2c;
  localparam logic [6:0] ADDR_SEL_HIGH = 7'h2d;
  // internal register map
  localparam logic [7:0] REG_DEVICE_IDENTITY = 8'h3d;
  // identity value is arbitrary, not a real part code
  localparam logic [7:0] IDENTITY_VALUE = 8'h5a;
  // clock and timeout figures
  localparam int CLK_MHZ = 125;
  localparam int TIMEOUT_MIN_MS = 15;
  localparam int TIMEOUT_MAX_MS = 35;
  // timeout set exactly at the minimum, no rounding
  localparam int TIMEOUT_CYCLES = TIMEOUT_MIN_MS * 1000 * CLK_MHZ;
  // bit counter values
  localparam logic [3:0] BIT_ADDR_LATCH = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  // start-up strap capture delay after reset release
  localparam logic [1:0] STRAP_WAIT = 2'h2;
endpackage : sas_pkg

//--- design/sas_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for a group of levels
module sas_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic rstB,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_reg;

  // first stage read only by the second
  always_ff @(posedge clk or negedge rstB) begin
    if (!rstB) begin
      meta_reg <= '1;
      dout <= '1;
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule : sas_sync

//--- design/sas_slave.sv
`timescale 1ns/1ps
// Notes on behaviour
// - strap enable high: answer at 0x2E
// - strap enable low: select pin picks address
// - straps sampled once after power-up
// - address frozen on first match, eighth rise
// - after freezing, strap changes ignored
// - compare upper seven bits of address byte
// - SCL low too long aborts; can disable
// - identity register at 0x3D, read only
// - alert pin reconfigurable as open-drain alert
// - timeout disable and alert enable are pins, not bus controls
// - select low 0x2C, select high 0x2D
// - acknowledge match by pulling SDA low
module sas_slave #(
  parameter int TIMEOUT_CYC = sas_pkg::TIMEOUT_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic address_strap_enable,
  input wire logic addrSelect,
  input wire logic timeoutDisable,
  input wire logic alertEnable,
  input wire logic limitAlarm,
  output logic alertOut,
  output logic alertOe,
  output logic addrFrozen
);
  // reset release and synchronised bus lines
  // the bus lines come from a resolved open-drain wire, so the
  // slave also sees its own pull-down echoed back through here
  logic rstMeta_reg; // first reset release stage
  logic rstB; // released copy used by the rest of the block
  logic [1:0] busSync; // {scl, sda} after two flops
  logic sclQ_reg; // scl one cycle back
  logic sdaQ_reg; // sda one cycle back
  logic sclNow; // current scl level
  logic sdaNow; // current sda level

  // reset assert is immediate, release waits two edges
  // so no flop leaves reset on a half-settled edge
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_reg <= 1'b0;
      rstB <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstB <= rstMeta_reg;
    end
  end

  sas_sync #(.WIDTH(2)) uSync (
    .clk(mclk),
    .rstB(rstB),
    .din({sclIn, sdaIn}),
    .dout(busSync)
  );
  assign sclNow = busSync[1];
  assign sdaNow = busSync[0];

  // previous values for edge detection
  // reset to the idle high level so no false edge follows reset
  always_ff @(posedge mclk or negedge rstB) begin
    if (!rstB) begin
      sclQ_reg <= 1'b1;
      sdaQ_reg <= 1'b1;
    end else begin
      sclQ_reg <= sclNow;
      sdaQ_reg <= sdaNow;
    end
  end

  // bus events, all two cycles behind the pins
  // limitation: bus half periods must be well above three cycles
  logic sclRise; // scl low to high
  logic sclFall; // scl high to low
  logic startCond; // sda falls while scl high
  logic stopCond; // sda rises while scl high
  assign sclRise = sclNow & ~sclQ_reg;
  assign sclFall = ~sclNow & sclQ_reg;
  assign startCond = sclNow & sclQ_reg & sdaQ_reg & ~sdaNow;
  assign stopCond = sclNow & sclQ_reg & ~sdaQ_reg & sdaNow;

  // strap capture a few cycles after reset release
  // waiting lets the strap pins settle after power-up;
  // starts seen before the capture are ignored on purpose
  logic [1:0] strapCnt_reg; // settle counter
  logic strapDone_reg; // straps captured
  logic [6:0] candAddr_reg; // address picked by the straps
  logic [6:0] frozenAddr_reg; // address kept after first match
  logic [6:0] myAddr; // address in use now

  // one-shot capture; the straps are never read again
  always_ff @(posedge mclk or negedge rstB) begin
    if (!rstB) begin
      strapCnt_reg <= 2'h0;
      strapDone_reg <= 1'b0;
      candAddr_reg <= sas_pkg::ADDR_DEFAULT;
    end else if (!strapDone_reg) begin
      strapCnt_reg <= strapCnt_reg + 2'h1;
      if (strapCnt_reg == sas_pkg::STRAP_WAIT) begin
        strapDone_reg <= 1'b1;
        if (address_strap_enable)
          candAddr_reg <= sas_pkg::ADDR_DEFAULT;
        else if (addrSelect)
          candAddr_reg <= sas_pkg::ADDR_SEL_HIGH;
        else
          candAddr_reg <= sas_pkg::ADDR_SEL_LOW;
      end
    end
  end

  // frozen address wins once latched; straps no longer matter
  assign myAddr = addrFrozen ? frozenAddr_reg : candAddr_reg;

  // byte engine
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_WRITE = 5'b00100,
    ST_READ = 5'b01000,
    ST_WAIT = 5'b10000
  } sas_state_t;

  // last data bit count in a read byte
  localparam logic [3:0] BIT_LAST = 4'h7;

  sas_state_t state_reg; // byte engine state
  logic [3:0] bitCnt_reg; // bits seen in the current byte
  logic [7:0] shift_reg; // receive or transmit shifter
  logic rnw_reg; // direction bit of the address byte
  logic byteIdx_reg; // set once the pointer byte is in
  logic [7:0] ptr_reg; // register pointer
  logic [7:0] txByte; // byte returned on a read
  logic timeout; // clock held low too long
  logic [31:0] lowCnt_reg; // cycles of scl low in a transfer

  // only the identity register lives in this block
  assign txByte = (ptr_reg == sas_pkg::REG_DEVICE_IDENTITY) ?
                  sas_pkg::IDENTITY_VALUE : 8'h00;

  // clock-low watchdog
  // only counts inside a transfer so an idle low line is harmless;
  // saturates instead of wrapping; the abort to idle then clears the count, so the timeout lasts two cycles
  always_ff @(posedge mclk or negedge rstB) begin
    if (!rstB) begin
      lowCnt_reg <= 32'h0;
    end else if (sclNow || state_reg == ST_IDLE) begin
      lowCnt_reg <= 32'h0;
    end else if (lowCnt_reg < 32'(TIMEOUT_CYC)) begin
      lowCnt_reg <= lowCnt_reg + 32'h1;
    end
  end
  assign timeout = !timeoutDisable &&
                   (lowCnt_reg >= 32'(TIMEOUT_CYC));

  // protocol sequencing
  // priority: timeout, then start, then stop, then the byte engine;
  // sda only ever changes after a seen scl fall, so the line is
  // stable while the master samples it with scl high
  always_ff @(posedge mclk or negedge rstB) begin
    if (!rstB) begin
      state_reg <= ST_IDLE;
      bitCnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      rnw_reg <= 1'b0;
      byteIdx_reg <= 1'b0;
      ptr_reg <= 8'h00;
      sdaOut <= 1'b1;
      sdaOe <= 1'b0;
      addrFrozen <= 1'b0;
      frozenAddr_reg <= sas_pkg::ADDR_DEFAULT;
    end else if (timeout) begin
      state_reg <= ST_IDLE;
      sdaOe <= 1'b0;
      sdaOut <= 1'b1;
    end else if (startCond && strapDone_reg) begin
      state_reg <= ST_ADDR;
      bitCnt_reg <= 4'h0;
      byteIdx_reg <= 1'b0;
      sdaOe <= 1'b0;
    end else if (stopCond) begin
      state_reg <= ST_IDLE;
      sdaOe <= 1'b0;
    end else begin
      unique case (state_reg)
        // nothing to do until a start
        ST_IDLE: begin
          sdaOe <= 1'b0;
        end
        // address and write bytes share the receive path
        ST_ADDR, ST_WRITE: begin
          if (sclRise && bitCnt_reg < sas_pkg::BIT_ACK) begin
            shift_reg <= {shift_reg[6:0], sdaNow};
            // eighth rise closes the seven address bits
            if (state_reg == ST_ADDR && bitCnt_reg == sas_pkg::BIT_ADDR_LATCH
                && shift_reg[6:0] == myAddr && !addrFrozen) begin
              addrFrozen <= 1'b1;
              frozenAddr_reg <= myAddr;
            end
            bitCnt_reg <= bitCnt_reg + 4'h1;
          end else if (sclFall && bitCnt_reg == sas_pkg::BIT_ACK) begin
            if (state_reg == ST_ADDR) begin
              if (shift_reg[7:1] == myAddr) begin
                sdaOe <= 1'b1;
                sdaOut <= 1'b0;
                rnw_reg <= shift_reg[0];
              end else begin
                state_reg <= ST_WAIT;
              end
            end else begin
              sdaOe <= 1'b1;
              sdaOut <= 1'b0;
              // first byte loads the pointer; others go nowhere here
              if (!byteIdx_reg)
                ptr_reg <= shift_reg;
              byteIdx_reg <= 1'b1;
            end
            bitCnt_reg <= 4'h9;
          end else if (sclFall && bitCnt_reg == 4'h9) begin
            bitCnt_reg <= 4'h0;
            if (state_reg == ST_ADDR && rnw_reg) begin
              state_reg <= ST_READ;
              shift_reg <= {txByte[6:0], 1'b0};
              sdaOe <= ~txByte[7];
              sdaOut <= 1'b0;
            end else begin
              state_reg <= ST_WRITE;
              sdaOe <= 1'b0;
            end
          end
        end
        // one byte out, msb first, changed on each scl fall
        ST_READ: begin
          if (sclFall) begin
            if (bitCnt_reg < BIT_LAST) begin
              sdaOe <= ~shift_reg[7];
              shift_reg <= {shift_reg[6:0], 1'b0};
              bitCnt_reg <= bitCnt_reg + 4'h1;
            end else begin
              // release for master ack; stay released till start or stop
              sdaOe <= 1'b0;
              state_reg <= ST_WAIT;
            end
          end
        end
        // not addressed or done: hands off until start or stop
        ST_WAIT: begin
          sdaOe <= 1'b0;
        end
        // illegal one-hot code: recover to idle
        default: begin
          state_reg <= ST_IDLE;
          sdaOe <= 1'b0;
        end
      endcase
    end
  end

  // alert pin: open drain, pulled low on alarm when enabled
  // data level is fixed low; only the enable moves, so the pin
  // can never be driven high against other open-drain parties
  always_ff @(posedge mclk or negedge rstB) begin
    if (!rstB) begin
      alertOut <= 1'b1;
      alertOe <= 1'b0;
    end else begin
      alertOut <= 1'b0;
      alertOe <= alertEnable & limitAlarm;
    end
  end
endmodule : sas_slave

//--- tb/sas_slave_assertions.sv
`timescale 1ns/1ps
// watches the slave pins only; bus latencies are loose, counts exact
module sas_slave_assertions #(
  parameter int TIMEOUT_CYC = 200
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic address_strap_enable,
  input wire logic addrSelect,
  input wire logic timeoutDisable,
  input wire logic alertEnable,
  input wire logic limitAlarm,
  input wire logic alertOut,
  input wire logic alertOe,
  input wire logic addrFrozen
);
  int lowCnt; // cycles of scl low while timeout armed
  // counter restarts on any scl high so only one stall is measured
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) lowCnt <= 0;
    else lowCnt <= (sclIn || timeoutDisable) ? 0 : lowCnt + 1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_alarm; (alertEnable && limitAlarm) [*5]; endsequence
  sequence s_quiet; (!alertEnable) [*5]; endsequence
  property p_alert_on; s_alarm |-> alertOe; endproperty
  property p_alert_off; s_quiet |-> !alertOe; endproperty
  property p_frozen_hold; addrFrozen |=> addrFrozen; endproperty
  property p_frozen_rise; $rose(addrFrozen) |-> sclIn; endproperty
  property p_pull_only; sdaOe |-> !sdaOut; endproperty
  property p_oe_rise; $rose(sdaOe) |-> !sclIn; endproperty
  property p_oe_fall; $fell(sdaOe) |-> !sclIn; endproperty
  property p_timeout; lowCnt > TIMEOUT_CYC + 8 |-> !sdaOe; endproperty
  a_alert_on: assert property (p_alert_on)
    else $error("alert not driven");
  a_alert_off: assert property (p_alert_off)
    else $error("alert driven while off");
  a_frozen_hold: assert property (p_frozen_hold)
    else $error("address unfroze");
  a_frozen_rise: assert property (p_frozen_rise)
    else $error("freeze outside clock high");
  a_pull_only: assert property (p_pull_only)
    else $error("sda driven high");
  a_oe_rise: assert property (p_oe_rise)
    else $error("sda taken while clock high");
  a_oe_fall: assert property (p_oe_fall)
    else $error("sda freed while clock high");
  a_timeout: assert property (p_timeout)
    else $error("bus held past timeout");
endmodule : sas_slave_assertions

bind sas_slave sas_slave_assertions #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk (.*);

//--- tb/sas_master.sv
`timescale 1ns/1ps
// bus master model; sda open drain, released reads as pulled up; scl driven directly
module sas_master #(
  parameter int HALF = 16
) (
  input wire logic mclk,
  input wire logic sda,
  output logic scl,
  output logic sdaLow
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge mclk);
  endtask : wt
  // start: sda falls while scl high
  task automatic start();
    sdaLow = 1'b0;
    wt(4);
    scl = 1'b1;
    wt(HALF);
    sdaLow = 1'b1;
    wt(HALF);
    scl = 1'b0;
  endtask : start
  // stop: sda rises while scl high
  task automatic stop();
    sdaLow = 1'b1;
    wt(4);
    scl = 1'b1;
    wt(HALF);
    sdaLow = 1'b0;
    wt(HALF);
  endtask : stop
  // nine bits msb first; data moves only while scl is low
  task automatic bits(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      wt(4);
      sdaLow = !tx[i];
      wt(HALF);
      scl = 1'b1;
      wt(HALF / 2);
      rx[i] = sda;
      wt(HALF / 2);
      scl = 1'b0;
    end
  endtask : bits
endmodule : sas_master

//--- tb/smbus_slave_address_select_tb.sv
`timescale 1ns/1ps
module smbus_slave_address_select_tb;
  logic mclk, rst_b, strapEn, addrSel, toDis, alertEn, alarm, scl, mLow;
  logic sdaOut, sdaOe, alertOut, alertOe, frozen, k;
  logic [8:0] r;
  logic [7:0] d;
  logic [6:0] a;
  logic [8:0] rows [4]; // straps beside expected address
  int failures = 0;
  int checks = 0;
  wire sda = !(mLow || sdaOe); // open drain with pull-up
  sas_slave #(.TIMEOUT_CYC(200)) dut (.mclk(mclk), .rst_b(rst_b),
    .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .address_strap_enable(strapEn), .addrSelect(addrSel),
    .timeoutDisable(toDis), .alertEnable(alertEn), .limitAlarm(alarm),
    .alertOut(alertOut), .alertOe(alertOe), .addrFrozen(frozen));
  sas_master m (.mclk(mclk), .sda(sda), .scl(scl), .sdaLow(mLow));
  always #4 mclk = !mclk;
  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_byte
  // one byte plus the slave's acknowledge slot
  task automatic xb(input logic [7:0] b);
    m.bits({b, 1'b1}, r);
    k = !r[0];
  endtask : xb
  task automatic rd(input logic [6:0] ad);
    m.start();
    xb({ad, 1'b1});
    chk_bit(k, 1'b1);
    m.bits(9'h1ff, r);
    d = r[8:1];
    m.stop();
  endtask : rd
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  // cut a hang well past the expected run length
  initial begin
    repeat (80000) @(posedge mclk);
    failures++;
    wrap_up();
  end
  initial begin
    {mclk, rst_b, strapEn, addrSel, toDis, alertEn, alarm} = 7'h08;
    rows = '{{2'b10, sas_pkg::ADDR_DEFAULT}, {2'b11, sas_pkg::ADDR_DEFAULT},
      {2'b00, sas_pkg::ADDR_SEL_LOW}, {2'b01, sas_pkg::ADDR_SEL_HIGH}};
    for (int i = 0; i < 4; i++) begin
      a = rows[i][6:0];
      {strapEn, addrSel} = rows[i][8:7];
      rst_b = 1'b0;
      m.wt(10);
      rst_b = 1'b1;
      m.wt(8);
      chk_bit(frozen, 1'b0);
      chk_bit(sdaOe, 1'b0);
      {strapEn, addrSel} = ~rows[i][8:7]; // straps move after sampling
      m.start();
      xb({a ^ 7'h01, 1'b0});
      m.stop();
      chk_bit(k, 1'b0);
      chk_bit(frozen, 1'b0);
      m.start();
      xb({a, 1'b0});
      chk_bit(k, 1'b1);
      chk_bit(frozen, 1'b1);
      xb(sas_pkg::REG_DEVICE_IDENTITY);
      xb(8'ha5); // write to a read-only place
      m.stop();
      rd(a);
      chk_byte(d, sas_pkg::IDENTITY_VALUE);
    end
    m.start();
    xb({a, 1'b0});
    xb(8'h00);
    m.stop();
    rd(a);
    chk_byte(d, 8'h00);
    // stall inside a read while the slave holds sda low
    m.start();
    xb({a, 1'b1});
    m.wt(8);
    chk_bit(sdaOe, 1'b1);
    chk_bit(sdaOut, 1'b0);
    m.wt(300);
    chk_bit(sdaOe, 1'b0);
    m.stop();
    toDis = 1'b1;
    m.start();
    xb({a, 1'b1});
    m.wt(300);
    chk_bit(sdaOe, 1'b1);
    m.bits(9'h1ff, r);
    m.stop();
    chk_byte(r[8:1], 8'h00);
    {alertEn, alarm} = 2'b11;
    m.wt(8);
    chk_bit(alertOe, 1'b1);
    chk_bit(alertOut, 1'b0);
    alertEn = 1'b0;
    m.wt(8);
    chk_bit(alertOe, 1'b0);
    wrap_up();
  end
endmodule : smbus_slave_address_select_tb
